/* File: dv/host_bus_model.sv */
// two-wire bus master standing in for the host processor
// assumes the bench resolves the wired data line and feeds it back
`timescale 1ns/1ns
module host_bus_model (
	input wire logic clk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	// clock stands high and data is released outside frames
	initial begin
		scl_out = 1'h1;
		sda_out = 1'h1;
	end

	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick

	task automatic start_cond();
		sda_out = 1'h1;
		scl_out = 1'h1;
		tick(4);
		sda_out = 1'h0;
		tick(4);
		scl_out = 1'h0;
		tick(2);
	endtask : start_cond

	task automatic stop_cond();
		sda_out = 1'h0;
		tick(2);
		scl_out = 1'h1;
		tick(4);
		sda_out = 1'h1;
		tick(6);
	endtask : stop_cond

	// one pulse: data moves only while clock is low, line read mid-high
	task automatic clock_bit(input logic b, output logic r);
		sda_out = b;
		tick(7);
		scl_out = 1'h1;
		tick(3);
		r = sda_in;
		tick(3);
		scl_out = 1'h0;
		tick(1);
	endtask : clock_bit

	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(b[i], r);
		end
		clock_bit(1'h1, r);
		ack = ~r;
	endtask : send_byte

	// more=1 acknowledges and asks for another byte, 0 lets the device go
	task automatic get_byte(input logic more, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'h1, r);
			b[i] = r;
		end
		clock_bit(~more, r);
	endtask : get_byte
endmodule : host_bus_model

/* File: dv/tb_pll_serial_ctrl.sv */
// self-checking bench for the synthesizer two-wire control slave
// assumes a pull-up on the data line, modelled by the wired-and below
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_count++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module tb_pll_serial_ctrl;
	localparam logic [7:0] addr_w = {5'h18, 2'h2, 1'h0};
	localparam logic [7:0] addr_r = {5'h18, 2'h2, 1'h1};
	logic clk, rstn, por, supply_low, lock;
	logic [1:0] chip_sel, port_in;
	logic [2:0] level;
	logic scl, host_sda, sda_out, sda_oe, sda_wire;
	logic pump, tristate, route, feed, tune_off, upper;
	logic [14:0] divider;
	logic [1:0] test_sel, ref_sel;
	logic [7:0] ratio;
	logic [3:0] ports;
	logic [1:0] ref_tab [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
	logic [7:0] ratio_tab [4] = '{8'h50, 8'h80, 8'h40, 8'h50};
	logic [3:0] port_tab [4] = '{4'h4, 4'h3, 4'hB, 4'h8};
	int err_count = 0;
	int num_checks = 0;

	assign sda_wire = (sda_oe ? 1'h1 : sda_out) & host_sda;

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	pll_serial_ctrl u_pll_serial_ctrl (
		.CLK_IN(clk), .RSTN_IN(rstn), .SCL_IN(scl), .SDA_IN(sda_wire),
		.SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .POWER_ON_RESET_IN(por),
		.SUPPLY_LOW_IN(supply_low), .CHIP_SELECT_IN(chip_sel), .LOCK_INDICATOR_IN(lock),
		.PORT_INPUT_LEVEL_IN(port_in), .LEVEL_CODE_IN(level), .DIVIDER_RATIO_OUT(divider),
		.PUMP_CURRENT_SELECT_OUT(pump), .TEST_SELECT_OUT(test_sel),
		.PUMP_TRISTATE_OUT(tristate), .TEST_ROUTE_OUT(route), .TEST_FEED_OUT(feed),
		.REFDIV_SELECT_OUT(ref_sel), .REFDIV_RATIO_OUT(ratio),
		.TUNING_OUTPUT_DISABLE_OUT(tune_off), .SWITCH_OUTPUT_OUT(ports),
		.UPPER_BAND_OUT(upper)
	);

	host_bus_model u_host_bus_model (
		.clk_in(clk), .sda_in(sda_wire), .scl_out(scl), .sda_out(host_sda)
	);

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic put(input logic [7:0] b, input logic exp_ack);
		logic ack;
		u_host_bus_model.send_byte(b, ack);
		`CHK("ack", exp_ack, ack)
	endtask : put

	function automatic logic [7:0] stat(input logic flag);
		return {flag, lock, 1'h0, port_in, level};
	endfunction : stat

	task automatic get(input logic more, input logic [7:0] exp);
		logic [7:0] b;
		u_host_bus_model.get_byte(more, b);
		`CHK("status", exp, b)
	endtask : get

	// host acks the first byte so a second follows, then lets go
	task automatic read_once(input logic flag);
		u_host_bus_model.start_cond();
		put(addr_r, 1'h1);
		get(1'h1, stat(flag));
		get(1'h0, stat(flag));
		u_host_bus_model.tick(6);
		`CHK("released", 1'h1, sda_oe)
		u_host_bus_model.stop_cond();
	endtask : read_once

	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		$display("[ERR] watchdog expected finish seen hang");
		report_and_stop();
	end

	initial begin
		rstn = 1'h0;
		por = 1'h0;
		supply_low = 1'h0;
		lock = 1'h0;
		chip_sel = 2'h2;
		port_in = 2'h0;
		level = 3'h0;
		repeat (16) @(negedge clk);
		rstn = 1'h1;
		repeat (4) @(negedge clk);
		`CHK("divider reset", 15'h0100, divider)
		`CHK("ratio reset", 8'h50, ratio)
		$display("test reset done");
		for (int cs = 0; cs < 4; cs++) begin
			chip_sel = 2'(cs);
			u_host_bus_model.tick(4);
			u_host_bus_model.start_cond();
			put({5'h18, 2'(cs), 1'h0}, 1'h1);
			u_host_bus_model.stop_cond();
		end
		chip_sel = 2'h2;
		u_host_bus_model.tick(4);
		$display("test address done");
		// a divider pair then four control pairs in one telegram, host never splits them
		u_host_bus_model.start_cond();
		put(addr_w, 1'h1);
		put(8'h12, 1'h1);
		`CHK("divider held", 15'h0100, divider)
		put(8'h34, 1'h1);
		u_host_bus_model.tick(6);
		`CHK("divider", 15'h1234, divider)
		for (int i = 0; i < 4; i++) begin
			put({1'h1, i[0], i[1:0], 1'h1, ref_tab[i], i[1]}, 1'h1);
			put({4'h0, port_tab[i]}, 1'h1);
			u_host_bus_model.tick(6);
			`CHK("pump", i[0], pump)
			`CHK("test", i[1:0], test_sel)
			`CHK("tristate", i[1:0] == 2'h1, tristate)
			`CHK("route", i[1:0] == 2'h2, route)
			`CHK("feed", i[1:0] == 2'h3, feed)
			`CHK("ref sel", ref_tab[i], ref_sel)
			`CHK("ratio", ratio_tab[i], ratio)
			`CHK("tune off", i[1], tune_off)
			`CHK("ports", port_tab[i], ports)
			`CHK("band", port_tab[i][2], upper)
		end
		u_host_bus_model.stop_cond();
		$display("test write done");
		// wrong pin bits and wrong prefix: silence until the next start
		u_host_bus_model.start_cond();
		put(8'hC0, 1'h0);
		put(8'h05, 1'h0);
		put(8'h55, 1'h0);
		u_host_bus_model.stop_cond();
		u_host_bus_model.start_cond();
		put(8'hD4, 1'h0);
		u_host_bus_model.stop_cond();
		`CHK("divider kept", 15'h1234, divider)
		$display("test mismatch done");
		lock = 1'h1;
		port_in = 2'h2;
		level = 3'h4;
		u_host_bus_model.tick(4);
		read_once(1'h1);
		read_once(1'h0);
		supply_low = 1'h1;
		u_host_bus_model.tick(4);
		supply_low = 1'h0;
		lock = 1'h0;
		port_in = 2'h1;
		level = 3'h1;
		u_host_bus_model.tick(4);
		read_once(1'h1);
		$display("test read done");
		// power reset: a matching address must not be acknowledged
		por = 1'h1;
		u_host_bus_model.tick(4);
		u_host_bus_model.start_cond();
		put(addr_w, 1'h0);
		u_host_bus_model.stop_cond();
		por = 1'h0;
		u_host_bus_model.tick(4);
		read_once(1'h1);
		$display("test power reset done");
		report_and_stop();
	end
endmodule : tb_pll_serial_ctrl

/* File: hw/line_sampler.sv */
// synchronises the two bus lines and finds their edges
// assumes both pins are asynchronous to CLK_IN and idle high
`timescale 1ns/1ns
module line_sampler (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	line_if.drive ln
);
	logic [1:0] scl_meta;
	logic [1:0] sda_meta;
	logic scl_last;
	logic sda_last;

	// lines reset high so a bus idle at release makes no false edge
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			scl_meta <= 2'h3;
			sda_meta <= 2'h3;
			scl_last <= 1'h1;
			sda_last <= 1'h1;
		end else begin
			scl_meta <= {scl_meta[0], scl_in};
			sda_meta <= {sda_meta[0], sda_in};
			scl_last <= scl_meta[1];
			sda_last <= sda_meta[1];
		end
	end

	assign ln.scl = scl_meta[1];
	assign ln.sda = sda_meta[1];
	assign ln.scl_rise = scl_meta[1] & ~scl_last;
	assign ln.scl_fall = ~scl_meta[1] & scl_last;
	// data moving while clock stays high frames a telegram
	assign ln.start_seen = scl_meta[1] & scl_last & sda_last & ~sda_meta[1];
	assign ln.stop_seen = scl_meta[1] & scl_last & ~sda_last & sda_meta[1];

endmodule : line_sampler

/* File: hw/pll_serial_ctrl.sv */
// two-wire slave holding divider, loop control and port settings
// assumes pins are asynchronous; analog levels arrive pre-decoded
`timescale 1ns/1ns
`include "pll_ctrl_defs.svh"
module pll_serial_ctrl #(
	parameter logic BAND_ON_FOURTH = 1'h0
) (
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic SCL_IN,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE_OUT,
	input wire logic POWER_ON_RESET_IN,
	input wire logic SUPPLY_LOW_IN,
	input wire logic [1:0] CHIP_SELECT_IN,
	input wire logic LOCK_INDICATOR_IN,
	input wire logic [1:0] PORT_INPUT_LEVEL_IN,
	input wire logic [2:0] LEVEL_CODE_IN,
	output logic [14:0] DIVIDER_RATIO_OUT,
	output logic PUMP_CURRENT_SELECT_OUT,
	output logic [1:0] TEST_SELECT_OUT,
	output logic PUMP_TRISTATE_OUT,
	output logic TEST_ROUTE_OUT,
	output logic TEST_FEED_OUT,
	output logic [1:0] REFDIV_SELECT_OUT,
	output logic [7:0] REFDIV_RATIO_OUT,
	output logic TUNING_OUTPUT_DISABLE_OUT,
	output logic [3:0] SWITCH_OUTPUT_OUT,
	output logic UPPER_BAND_OUT
);

	// ************************************************
	// helpers
	// ************************************************
	function automatic logic address_match(input pll_ctrl_pkg::byte_t b,
			input logic [1:0] sel);
		address_match = (b[7:3] == `ADDR_PREFIX) && (b[2:1] == sel);
	endfunction : address_match
	function automatic logic [7:0] ratio_of(input logic [1:0] sel);
		if (!sel[0])
			ratio_of = `RATIO_SECOND_LOW;
		else if (!sel[1])
			ratio_of = `RATIO_SECOND_HIGH_FIRST_LOW;
		else
			ratio_of = `RATIO_BOTH_HIGH;
	endfunction : ratio_of
	// ************************************************
	// pin synchronisers
	// ************************************************
	logic [9:0] ext_meta;
	logic [9:0] ext_sync;
	wire [9:0] ext_raw = {POWER_ON_RESET_IN, SUPPLY_LOW_IN, CHIP_SELECT_IN,
		LOCK_INDICATOR_IN, PORT_INPUT_LEVEL_IN, LEVEL_CODE_IN};
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			ext_meta <= 10'h000;
			ext_sync <= 10'h000;
		end else begin
			ext_meta <= ext_raw;
			ext_sync <= ext_meta;
		end
	end
	wire por_active = ext_sync[9];
	wire supply_low = ext_sync[8];
	wire [1:0] chip_sel = ext_sync[7:6];
	wire lock_indicator = ext_sync[5];
	wire [1:0] port_level = ext_sync[4:3];
	wire [2:0] level_code = ext_sync[2:0];
	line_if ln ();
	line_sampler u_sampler (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.scl_in(SCL_IN),
		.sda_in(SDA_IN),
		.ln(ln)
	);

	// ************************************************
	// sequencer state
	// ************************************************
	pll_ctrl_pkg::ser_state_e state, next_state;
	logic [2:0] bit_cnt, next_cnt;
	pll_ctrl_pkg::byte_t rx_shift, next_rx;
	pll_ctrl_pkg::byte_t tx_shift, next_tx;
	pll_ctrl_pkg::byte_t hold, next_hold;
	logic byte_done, next_done;
	logic pair_open, next_open;
	logic host_ack, next_ack;
	logic read_seen, next_read_seen;
	logic next_oe;
	logic commit_div, commit_ctl, read_end;
	logic power_flag;
	// unused bit reads zero
	wire [7:0] status_byte = {power_flag, lock_indicator, `STATUS_UNUSED,
		port_level, level_code};
	wire addr_ok = address_match(rx_shift, chip_sel);
	wire dir_read = rx_shift[0];
	wire [14:0] pair_divider = {hold[6:0], rx_shift};
	wire pair_is_ctl = hold[`TYPE_BIT];
	always_comb begin
		next_state = state;
		next_cnt = bit_cnt;
		next_rx = rx_shift;
		next_tx = tx_shift;
		next_hold = hold;
		next_done = byte_done;
		next_open = pair_open;
		next_ack = host_ack;
		next_read_seen = read_seen;
		next_oe = SDA_OE_OUT;
		commit_div = 1'h0;
		commit_ctl = 1'h0;
		read_end = 1'h0;
		if (por_active) begin
			// bus must stay free while the supply settles
			next_state = pll_ctrl_pkg::ST_IDLE;
			next_oe = 1'h1;
			next_done = 1'h0;
			next_open = 1'h0;
			next_read_seen = 1'h0;
		end else if (ln.stop_seen) begin
			next_state = pll_ctrl_pkg::ST_IDLE;
			next_oe = 1'h1;
			read_end = read_seen;
			next_read_seen = 1'h0;
		end else if (ln.start_seen) begin
			// a repeated start also closes a pending read
			next_state = pll_ctrl_pkg::ST_ADDR;
			next_cnt = 3'h0;
			next_done = 1'h0;
			next_open = 1'h0;
			next_oe = 1'h1;
			read_end = read_seen;
			next_read_seen = 1'h0;
		end else begin
			case (state)
			pll_ctrl_pkg::ST_ADDR, pll_ctrl_pkg::ST_WDATA: begin
				if (ln.scl_rise) begin
					next_rx = {rx_shift[6:0], ln.sda};
					next_cnt = 3'(bit_cnt + 3'h1);
					next_done = (bit_cnt == 3'h7);
				end else if (ln.scl_fall && byte_done) begin
					next_done = 1'h0;
					if (state == pll_ctrl_pkg::ST_WDATA) begin
						next_oe = 1'h0;
						next_state = pll_ctrl_pkg::ST_WACK;
					end else if (addr_ok) begin
						next_oe = 1'h0;
						next_read_seen = dir_read;
						next_state = pll_ctrl_pkg::ST_ADDR_ACK;
					end else begin
						next_state = pll_ctrl_pkg::ST_IGNORE;
					end
				end
			end
			pll_ctrl_pkg::ST_ADDR_ACK: begin
				if (ln.scl_fall) begin
					next_cnt = 3'h0;
					if (read_seen) begin
						next_oe = status_byte[7];
						next_tx = {status_byte[6:0], 1'h0};
						next_state = pll_ctrl_pkg::ST_RDATA;
					end else begin
						next_oe = 1'h1;
						next_state = pll_ctrl_pkg::ST_WDATA;
					end
				end
			end
			pll_ctrl_pkg::ST_WACK: begin
				if (ln.scl_fall) begin
					next_oe = 1'h1;
					next_cnt = 3'h0;
					next_state = pll_ctrl_pkg::ST_WDATA;
					// the host keeps each pair whole, so alternate blindly
					if (!pair_open) begin
						next_hold = rx_shift;
						next_open = 1'h1;
					end else begin
						commit_ctl = pair_is_ctl;
						commit_div = !pair_is_ctl;
						next_open = 1'h0;
					end
				end
			end
			pll_ctrl_pkg::ST_RDATA: begin
				if (ln.scl_fall) begin
					// bit 7 went out at the ack fall, bit 0 at count 6
					if (bit_cnt == 3'h7) begin
						next_oe = 1'h1;
						next_cnt = 3'h0;
						next_state = pll_ctrl_pkg::ST_RACK;
					end else begin
						next_oe = tx_shift[7];
						next_tx = {tx_shift[6:0], 1'h0};
						next_cnt = 3'(bit_cnt + 3'h1);
					end
				end
			end
			pll_ctrl_pkg::ST_RACK: begin
				if (ln.scl_rise) begin
					next_ack = ~ln.sda;
				end else if (ln.scl_fall) begin
					if (host_ack) begin
						next_oe = status_byte[7];
						next_tx = {status_byte[6:0], 1'h0};
						next_cnt = 3'h0;
						next_state = pll_ctrl_pkg::ST_RDATA;
					end else begin
						next_oe = 1'h1;
						next_state = pll_ctrl_pkg::ST_IGNORE;
					end
				end
			end
			pll_ctrl_pkg::ST_IDLE, pll_ctrl_pkg::ST_IGNORE: begin
				next_oe = 1'h1;
			end
			default: begin
				next_state = pll_ctrl_pkg::ST_IDLE;
				next_oe = 1'h1;
			end
			endcase
		end
	end
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			state <= pll_ctrl_pkg::ST_IDLE;
			bit_cnt <= 3'h0;
			rx_shift <= 8'h00;
			tx_shift <= 8'h00;
			hold <= 8'h00;
			byte_done <= 1'h0;
			pair_open <= 1'h0;
			host_ack <= 1'h0;
			read_seen <= 1'h0;
			SDA_OE_OUT <= 1'h1;
		end else begin
			state <= next_state;
			bit_cnt <= next_cnt;
			rx_shift <= next_rx;
			tx_shift <= next_tx;
			hold <= next_hold;
			byte_done <= next_done;
			pair_open <= next_open;
			host_ack <= next_ack;
			read_seen <= next_read_seen;
			SDA_OE_OUT <= next_oe;
		end
	end
	// open-drain: only ever drives low, enable does the work
	always_ff @(posedge CLK_IN) begin
		SDA_OUT <= 1'h0;
	end

	// ************************************************
	// power-on flag
	// ************************************************
	// a new supply dip wins over a clearing read in the same cycle
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN)
			power_flag <= `POWER_FLAG_RESET;
		else if (por_active || supply_low)
			power_flag <= 1'h1;
		else if (read_end)
			power_flag <= 1'h0;
	end

	// ************************************************
	// setting registers
	// ************************************************
	wire [3:0] new_ports = rx_shift[3:0];
	wire new_band = BAND_ON_FOURTH ? new_ports[3] : new_ports[2];
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN)
			DIVIDER_RATIO_OUT <= `DIVIDER_RESET;
		else if (commit_div)
			DIVIDER_RATIO_OUT <= pair_divider;
	end
	// the first control byte sits in hold, the second in rx_shift
	wire [1:0] hold_test = {hold[`TEST_HI_BIT], hold[`TEST_LO_BIT]};
	wire [1:0] hold_ref = {hold[`REFSEL_FIRST_BIT], hold[`REFSEL_SECOND_BIT]};
	always_ff @(posedge CLK_IN) begin
		if (!RSTN_IN) begin
			PUMP_CURRENT_SELECT_OUT <= 1'h0;
			TEST_SELECT_OUT <= `TEST_RESET;
			PUMP_TRISTATE_OUT <= 1'h0;
			TEST_ROUTE_OUT <= 1'h0;
			TEST_FEED_OUT <= 1'h0;
			REFDIV_SELECT_OUT <= `REFSEL_RESET;
			REFDIV_RATIO_OUT <= ratio_of(`REFSEL_RESET);
			TUNING_OUTPUT_DISABLE_OUT <= 1'h0;
			SWITCH_OUTPUT_OUT <= `PORTS_RESET;
			UPPER_BAND_OUT <= 1'h0;
		end else if (commit_ctl) begin
			PUMP_CURRENT_SELECT_OUT <= hold[`PUMP_BIT];
			TEST_SELECT_OUT <= hold_test;
			PUMP_TRISTATE_OUT <= (hold_test == 2'h1);
			TEST_ROUTE_OUT <= (hold_test == 2'h2);
			TEST_FEED_OUT <= (hold_test == 2'h3);
			REFDIV_SELECT_OUT <= hold_ref;
			REFDIV_RATIO_OUT <= ratio_of(hold_ref);
			TUNING_OUTPUT_DISABLE_OUT <= hold[`TUNE_OFF_BIT];
			SWITCH_OUTPUT_OUT <= new_ports;
			UPPER_BAND_OUT <= new_band;
		end
	end

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	sequence s_addr_byte_taken;
		state == pll_ctrl_pkg::ST_ADDR && ln.scl_fall && byte_done
			&& !por_active && !ln.stop_seen && !ln.start_seen;
	endsequence
	sequence s_read_ack_ends;
		state == pll_ctrl_pkg::ST_ADDR_ACK && ln.scl_fall && read_seen
			&& !por_active && !ln.stop_seen && !ln.start_seen;
	endsequence
	sequence s_host_nack;
		state == pll_ctrl_pkg::ST_RACK && ln.scl_fall && !host_ack
			&& !por_active && !ln.stop_seen && !ln.start_seen;
	endsequence

	a_ack_on_match: assert property (
		s_addr_byte_taken ##0 addr_ok |=> !SDA_OE_OUT
			&& state == pll_ctrl_pkg::ST_ADDR_ACK)
		else $error("no acknowledge after matching address");
	a_mismatch_silent: assert property (
		s_addr_byte_taken ##0 !addr_ok |=> SDA_OE_OUT
			&& state == pll_ctrl_pkg::ST_IGNORE)
		else $error("mismatched address was acknowledged");
	a_status_first_bit: assert property (
		s_read_ack_ends |=> SDA_OE_OUT == $past(status_byte[7])
			&& state == pll_ctrl_pkg::ST_RDATA)
		else $error("status byte did not start after read acknowledge");
	a_nack_releases: assert property (
		s_host_nack |=> SDA_OE_OUT [*2])
		else $error("data line held after host declined");
	a_por_free_bus: assert property (
		por_active |=> SDA_OE_OUT)
		else $error("data line driven during power reset");
	a_ignore_quiet: assert property (
		state == pll_ctrl_pkg::ST_IGNORE |-> SDA_OE_OUT)
		else $error("data line driven while ignoring");
	a_divider_pair: assert property (
		commit_div |=> DIVIDER_RATIO_OUT == $past(pair_divider)
			&& $past(state) == pll_ctrl_pkg::ST_WACK)
		else $error("divider not taken from pair");
	a_divider_held: assert property (
		!commit_div |=> $stable(DIVIDER_RATIO_OUT))
		else $error("divider changed without complete pair");
	a_flag_clear: assert property (
		read_end && !por_active && !supply_low |=> !power_flag)
		else $error("power flag not cleared after read");
	a_flag_set: assert property (
		supply_low |=> power_flag)
		else $error("power flag missed supply dip");
	a_ratio_decode: assert property (
		commit_ctl ##1 REFDIV_SELECT_OUT == 2'h3
			|-> REFDIV_RATIO_OUT == `RATIO_BOTH_HIGH)
		else $error("reference ratio wrong for both bits set");
	a_test_tristate: assert property (
		PUMP_TRISTATE_OUT == (TEST_SELECT_OUT == 2'h1))
		else $error("pump tristate out of step with test bits");
	a_band_follows: assert property (
		UPPER_BAND_OUT == (BAND_ON_FOURTH ? SWITCH_OUTPUT_OUT[3]
			: SWITCH_OUTPUT_OUT[2]))
		else $error("band mode disagrees with port bit");

endmodule : pll_serial_ctrl

/* File: shared/line_if.sv */
// bus line events passed from the sampler to the sequencer
// assumes both ends run on the same system clock
`timescale 1ns/1ns
interface line_if;
	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	modport drive (
		output scl, sda, scl_rise, scl_fall, start_seen, stop_seen
	);
	modport use_side (
		input scl, sda, scl_rise, scl_fall, start_seen, stop_seen
	);
endinterface : line_if

/* File: shared/pll_ctrl_defs.svh */
// constants for the synthesizer two-wire control slave
// assumes the includer supplies clock, reset and synchronised pins
//
// Operation
// - start and stop framed by data on high clock
// - data changes on low clock, sampled rising
// - eight bits MSB first, ninth pulse acknowledges
// - address must equal prefix plus pin bits
// - address LSB zero writes, one reads
// - data byte top bit picks pair type
// - divider is fifteen bits across pair
// - read match acknowledges then sends status
// - host ack repeats status, else release
// - status: flag, lock, zero, inputs, level
// - power flag set at power, cleared after read
// - never pull data low during power reset
// - pump select zero low current, one high
// - control LSB one disables tuning output
// - port bit one turns output on
// - two test bits select four modes
// - reference select bits pick three ratios
// - level code reports five supply bands
// - address pin gives two address bits
`ifndef PLL_CTRL_DEFS_SVH
`define PLL_CTRL_DEFS_SVH

// ************************************************
// address and field layout
// ************************************************
`define ADDR_PREFIX 5'h18
`define TYPE_BIT 7
`define PUMP_BIT 6
`define TEST_HI_BIT 5
`define TEST_LO_BIT 4
`define REFSEL_FIRST_BIT 2
`define REFSEL_SECOND_BIT 1
`define TUNE_OFF_BIT 0
`define STATUS_UNUSED 1'h0

// ************************************************
// reference ratios, reset values and synchroniser depth
// ************************************************
`define RATIO_SECOND_LOW 8'h50
`define RATIO_SECOND_HIGH_FIRST_LOW 8'h80
`define RATIO_BOTH_HIGH 8'h40
`define DIVIDER_RESET 15'h0100
`define REFSEL_RESET 2'h0
`define TEST_RESET 2'h0
`define PORTS_RESET 4'h0
`define POWER_FLAG_RESET 1'h1
`define SYNC_STAGES 2

`endif

/* File: shared/pll_ctrl_pkg.sv */
// types for the synthesizer two-wire control slave
// assumes nothing beyond a SystemVerilog compiler
package pll_ctrl_pkg;

	// one-hot serial sequencer states
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_ADDR_ACK = 8'h04,
		ST_WDATA = 8'h08,
		ST_WACK = 8'h10,
		ST_RDATA = 8'h20,
		ST_RACK = 8'h40,
		ST_IGNORE = 8'h80
	} ser_state_e;

	typedef logic [7:0] byte_t;

endpackage : pll_ctrl_pkg
